/* rtl/ddcsd_cfg.svh */
// Constants of the down-converter back end: widths, reset values, filter taps.
// Assumes inclusion by bare name from files that need the numbers.
`ifndef DDCSD_CFG_SVH
`define DDCSD_CFG_SVH
`define DDCSD_SAMPLE_W 12
`define DDCSD_OUT_W 15
`define DDCSD_INT_W 18
`define DDCSD_ACC_W 32
`define DDCSD_PHW_W 16
`define DDCSD_STAGES 4
`define DDCSD_BUF_DEPTH 2
`define DDCSD_ACC_RST 32'h0000_0000
// Symmetric tap pairs: outer weight, centre weight, right shift
`define DDCSD_STD_OUTER 18'sh00001
`define DDCSD_STD_CENTER 18'sh00002
`define DDCSD_STD_SHIFT 2
`define DDCSD_WIDE_OUTER 18'sh00001
`define DDCSD_WIDE_CENTER 18'sh00006
`define DDCSD_WIDE_SHIFT 3
`endif

/* rtl/ddcsd_pkg.sv */
// Types shared by the down-converter back end.
// Assumes the constants header is compiled alongside.
package ddcsd_pkg;
  typedef enum logic [2:0] {DEC_NONE, DEC_2, DEC_4, DEC_8, DEC_16} ddcsd_dec_t;
endpackage

/* rtl/ddcsd_top.sv */
// Down-converter back end: two NCOs with phase offset and alignment,
// quadrant mixer, four-stage decimation chain and a two-entry output buffer.
// Assumes all inputs are synchronous to core_clk_in (20 MHz).
// Functional notes
// - Phase word left-justified, added to accumulator
// - Frequency change needs realignment via link or sysref
// - Align on sync deassertion after code groups
// - Single sysref pulse aligns armed devices
// - Align on first sysref rise after arming
// - Decimate by 2/4/8/16, 15-bit outputs
// - Real at 2, complex at 4/8/16
// - Output rate is clock over factor
// - Bypass delivers real 12-bit samples
// - Filters use symmetric taps around centre
// - Stage count per factor, final block selectable at 4 only
`timescale 1ns/1ps
`include "ddcsd_cfg.svh"
module ddcsd_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Sample stream in
  input wire logic [`DDCSD_SAMPLE_W-1:0] sample_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  // Oscillator configuration
  input wire logic [`DDCSD_ACC_W-1:0] freq_word_chan_a_in,
  input wire logic [`DDCSD_ACC_W-1:0] freq_word_chan_b_in,
  input wire logic [`DDCSD_PHW_W-1:0] phase_offset_word_chan_a_in,
  input wire logic [`DDCSD_PHW_W-1:0] phase_offset_word_chan_b_in,
  input wire logic mix_chan_b_sel_in,
  // Alignment control and link signals
  input wire logic osc_align_on_link_init_in,
  input wire logic osc_align_on_next_sysref_in,
  input wire logic serial_link_enable_in,
  input wire logic link_sync_in,
  input wire logic sysref_in,
  output logic align_pulse_out,
  // Decimation control
  input wire ddcsd_pkg::ddcsd_dec_t decim_sel_in,
  input wire logic wideband_quarter_select_in,
  // Sample stream out
  output logic [`DDCSD_OUT_W-1:0] out_i_out,
  output logic [`DDCSD_OUT_W-1:0] out_q_out,
  output logic out_complex_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int W = `DDCSD_INT_W;
  localparam int NS = `DDCSD_STAGES;
  localparam int BW = 2 * `DDCSD_OUT_W + 1;

  logic [`DDCSD_ACC_W-1:0] acc_a_q, acc_b_q, phase_a, phase_b;
  logic sync_q, sysref_q, next_q, armed_q, align_q;
  logic sync_rise, sysref_rise, next_rise, fire;
  logic acc_in, is_cplx;
  logic [2:0] nst;
  logic signed [W-1:0] x_s, mix_i, mix_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alignment events
  assign sync_rise = link_sync_in & ~sync_q;
  assign sysref_rise = sysref_in & ~sysref_q;
  assign next_rise = osc_align_on_next_sysref_in & ~next_q;
  // Link alignment only counts while the link is up; the receiver keeps
  // sync high before enabling, so enabling itself is no edge
  assign fire = (osc_align_on_link_init_in & serial_link_enable_in & sync_rise)
              | (armed_q & sysref_rise);
  assign align_pulse_out = align_q;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_q <= 1'b1;
      sysref_q <= 1'b0;
      next_q <= 1'b0;
      align_q <= 1'b0;
    end else begin
      sync_q <= link_sync_in;
      sysref_q <= sysref_in;
      next_q <= osc_align_on_next_sysref_in;
      align_q <= fire;
    end
  end

  // Arm on the write of the bit; a new arm in the firing cycle wins
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      armed_q <= 1'b0;
    end else if (next_rise) begin
      armed_q <= 1'b1;
    end else if (fire) begin
      armed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillators
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_a_q <= `DDCSD_ACC_RST;
      acc_b_q <= `DDCSD_ACC_RST;
    end else if (fire) begin
      acc_a_q <= `DDCSD_ACC_RST;
      acc_b_q <= `DDCSD_ACC_RST;
    end else begin
      acc_a_q <= acc_a_q + freq_word_chan_a_in;
      acc_b_q <= acc_b_q + freq_word_chan_b_in;
    end
  end

  assign phase_a = acc_a_q + {phase_offset_word_chan_a_in, 16'h0000};
  assign phase_b = acc_b_q + {phase_offset_word_chan_b_in, 16'h0000};

  // Quadrant mixer: coarse, but exact at the four cardinal phases
  always_comb begin
    logic [1:0] quad;
    quad = mix_chan_b_sel_in ? phase_b[31:30] : phase_a[31:30];
    x_s = W'(signed'({sample_in, 3'b000}));
    mix_i = '0;
    mix_q = '0;
    case (quad)
      2'd0: mix_i = x_s;
      2'd1: mix_q = -x_s;
      2'd2: mix_i = -x_s;
      2'd3: mix_q = x_s;
      default: mix_i = x_s;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decimation chain: stage NS-1 is the final block, earlier ones prepend
  always_comb begin
    case (decim_sel_in)
      ddcsd_pkg::DEC_2: nst = 3'd1;
      ddcsd_pkg::DEC_4: nst = 3'd2;
      ddcsd_pkg::DEC_8: nst = 3'd3;
      ddcsd_pkg::DEC_16: nst = 3'd4;
      default: nst = 3'd0;
    endcase
  end
  assign is_cplx = (nst >= 3'd2);
  assign acc_in = sample_valid_in & sample_ready_out;

  logic [NS:0] sv;
  logic signed [W-1:0] si [NS+1];
  logic signed [W-1:0] sq [NS+1];
  logic [NS-1:0] ph_q;
  assign sv[0] = 1'b0;
  assign si[0] = '0;
  assign sq[0] = '0;

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_stage
      logic signed [W-1:0] i1_q, i2_q, q1_q, q2_q, iin, qin, co, cc, yi, yq;
      logic vin, first, tog_q;
      int sh;
      // One flop per stage keeps each decimation phase in a single process
      assign ph_q[s] = tog_q;
      assign first = (3'(s) == 3'(NS) - nst);
      assign vin = first ? acc_in : sv[s];
      assign iin = first ? (is_cplx ? mix_i : x_s) : si[s];
      assign qin = first ? (is_cplx ? mix_q : '0) : sq[s];
      // Wider passband final block only for the quarter-rate mode
      always_comb begin
        if (s == NS - 1 && nst == 3'd2 && wideband_quarter_select_in) begin
          co = `DDCSD_WIDE_OUTER;
          cc = `DDCSD_WIDE_CENTER;
          sh = `DDCSD_WIDE_SHIFT;
        end else begin
          co = `DDCSD_STD_OUTER;
          cc = `DDCSD_STD_CENTER;
          sh = `DDCSD_STD_SHIFT;
        end
      end
      // Mirror pairs share one weight around the centre tap
      assign yi = W'((co * (iin + i2_q) + cc * i1_q) >>> sh);
      assign yq = W'((co * (qin + q2_q) + cc * q1_q) >>> sh);
      assign sv[s+1] = vin & ph_q[s] & (3'(s) >= 3'(NS) - nst);
      assign si[s+1] = yi;
      assign sq[s+1] = yq;
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          i1_q <= '0;
          i2_q <= '0;
          q1_q <= '0;
          q2_q <= '0;
          tog_q <= 1'b0;
        end else if (vin) begin
          i1_q <= iin;
          i2_q <= i1_q;
          q1_q <= qin;
          q2_q <= q1_q;
          tog_q <= ~tog_q;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; the chain is combinational from the accepted
  // sample, so refusing input while full loses nothing in flight
  logic wr_en, rd_en, wr_cplx;
  logic [`DDCSD_OUT_W-1:0] wr_i, wr_q;
  logic [BW-1:0] buf_q [`DDCSD_BUF_DEPTH];
  logic wp_q, rp_q;
  logic [1:0] cnt_q;

  assign wr_en = (nst == 3'd0) ? acc_in : sv[NS];
  assign wr_i = (nst == 3'd0) ? `DDCSD_OUT_W'(signed'(sample_in))
                              : si[NS][`DDCSD_OUT_W-1:0];
  assign wr_q = is_cplx ? sq[NS][`DDCSD_OUT_W-1:0] : '0;
  assign wr_cplx = is_cplx;
  assign rd_en = out_valid_out & out_ready_in;
  assign sample_ready_out = (cnt_q != 2'd2);
  assign out_valid_out = (cnt_q != 2'd0);
  assign {out_complex_out, out_i_out, out_q_out} = buf_q[rp_q];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (wr_en) begin
        buf_q[wp_q] <= {wr_cplx, wr_i, wr_q};
        wp_q <= ~wp_q;
      end
      if (rd_en) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, wr_en} - {1'b0, rd_en});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // A quarter-turn offset word on a cleared accumulator must land in quadrant one
  a_offset_top_half: assert property (
    acc_a_q == 32'h0000_0000 && !mix_chan_b_sel_in &&
    phase_offset_word_chan_a_in[15:14] == 2'b01 |-> mix_i == '0 && mix_q == -x_s)
    else $error("phase offset not in upper half");
  a_acc_advance: assert property (
    !fire |=> acc_a_q == $past(acc_a_q) + $past(freq_word_chan_a_in))
    else $error("accumulator did not advance");
  a_sync_align: assert property (
    osc_align_on_link_init_in && serial_link_enable_in && $rose(link_sync_in)
    |=> acc_a_q == 32'h0000_0000 && align_pulse_out)
    else $error("no align on sync release");
  a_sysref_align: assert property (
    armed_q && !sysref_q && sysref_in
    |=> acc_b_q == 32'h0000_0000 && acc_a_q == 32'h0000_0000)
    else $error("no align on sysref");
  a_arm_consumed: assert property (
    fire && !next_rise |=> !armed_q ##1 (!armed_q || $past(next_rise)))
    else $error("arm not consumed");
  a_align_source: assert property (
    fire |-> sync_rise || (armed_q && sysref_rise))
    else $error("spurious alignment");
  a_output_format: assert property (
    wr_en |-> wr_cplx ==
      (decim_sel_in inside {ddcsd_pkg::DEC_4, ddcsd_pkg::DEC_8, ddcsd_pkg::DEC_16}))
    else $error("wrong output format");
  a_bypass_rate: assert property (
    acc_in && decim_sel_in == ddcsd_pkg::DEC_NONE
    |-> wr_en && wr_i[14:11] == {4{sample_in[11]}})
    else $error("bypass sample lost");
  a_half_rate: assert property (
    decim_sel_in == ddcsd_pkg::DEC_2 && acc_in && !ph_q[NS-1] |-> !wr_en)
    else $error("decimate by two wrote early");
  a_buffer_full: assert property (
    cnt_q == 2'd2 |-> !sample_ready_out ##0 out_valid_out)
    else $error("full buffer accepted input");

  c_sync_align: cover property (osc_align_on_link_init_in && serial_link_enable_in && sync_rise);
  c_sysref_align: cover property (armed_q && sysref_rise);
  c_stall_full: cover property (cnt_q == 2'd2 && sample_valid_in);
  c_dec16_out: cover property (decim_sel_in == ddcsd_pkg::DEC_16 && wr_en);
endmodule // ddcsd_top

/* sim/ddcsd_partner.sv */
// Far side model: link receiver driving SYNC and the SYSREF source.
// Assumes one bench process calls its tasks, just after a clock edge.
`timescale 1ns/1ps
module ddcsd_partner (
  // Clock
  input wire logic core_clk_in,
  // Link signals
  output logic link_sync_out,
  output logic sysref_out
);
  initial begin
    link_sync_out = 1'b1;
    sysref_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Code group phase holds sync low, then all converters see the same rise
  task automatic sync_run(input int low_cyc);
    @(posedge core_clk_in);
    #5 link_sync_out = 1'b0;
    repeat (low_cyc) @(posedge core_clk_in);
    #5 link_sync_out = 1'b1;
  endtask
  // Single pulse, issued well apart from the arming write
  task automatic sysref_pulse();
    @(posedge core_clk_in);
    #5 sysref_out = 1'b1;
    repeat (2) @(posedge core_clk_in);
    #5 sysref_out = 1'b0;
  endtask
endmodule // ddcsd_partner

/* sim/tb_ddc_nco_sync_decimation.sv */
// Self-checking bench for the down-converter back end.
// Assumes the design, its package and header, and the far side model.
`timescale 1ns/1ps
`include "ddcsd_cfg.svh"
module tb_ddc_nco_sync_decimation;
  logic clk, rst_n, s_valid, s_ready, o_valid, o_ready, o_cplx, pulse;
  logic mix_b, link_init, arm, link_en, sync, sysref, wide;
  logic [11:0] sample;
  logic [31:0] fa, fb;
  logic [15:0] pa, pb;
  logic [14:0] o_i, o_q;
  ddcsd_pkg::ddcsd_dec_t dec;
  logic [30:0] got_q[$];
  int failures = 0, comparisons = 0, pulse_cnt = 0;

  ddcsd_top dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .sample_in(sample),
    .sample_valid_in(s_valid), .sample_ready_out(s_ready), .freq_word_chan_a_in(fa),
    .freq_word_chan_b_in(fb), .phase_offset_word_chan_a_in(pa),
    .phase_offset_word_chan_b_in(pb), .mix_chan_b_sel_in(mix_b),
    .osc_align_on_link_init_in(link_init), .osc_align_on_next_sysref_in(arm),
    .serial_link_enable_in(link_en), .link_sync_in(sync), .sysref_in(sysref),
    .align_pulse_out(pulse), .decim_sel_in(dec), .wideband_quarter_select_in(wide),
    .out_i_out(o_i), .out_q_out(o_q), .out_complex_out(o_cplx), .out_valid_out(o_valid),
    .out_ready_in(o_ready));
  ddcsd_partner partner_u (.core_clk_in(clk), .link_sync_out(sync), .sysref_out(sysref));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pre-update values are read at the edge, so no race with the design
  always @(posedge clk) begin
    if (o_valid === 1'b1 && o_ready === 1'b1) got_q.push_back({o_cplx, o_i, o_q});
    if (pulse === 1'b1) pulse_cnt++;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk);
    #5;
  endtask
  task automatic cmp_word(input logic [14:0] got, input logic [14:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic feed(input int n, input logic [11:0] x);
    int k = 0;
    int g = 0;
    sample = x;
    s_valid = 1'b1;
    while (k < n && g < 4000) begin
      @(posedge clk);
      if (s_ready === 1'b1) k++;
      g++;
      #5;
    end
    s_valid = 1'b0;
    if (k < n) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, k, n);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_bypass();
    got_q.delete();
    feed(4, 12'h800);
    repeat (3) step();
    cmp_word(15'(got_q.size()), 15'h0004);
    foreach (got_q[j]) cmp_word(got_q[j][29:15], 15'h7800);
    foreach (got_q[j]) cmp_flag(got_q[j][30] | (|got_q[j][14:0]), 1'b0);
    $display("test bypass done");
  endtask
  // Receiver stalls: the third word waits, none of them is lost
  task automatic t_stall();
    o_ready = 1'b0;
    got_q.delete();
    sample = 12'h123;
    s_valid = 1'b1;
    step();
    sample = 12'h456;
    step();
    sample = 12'h789;
    step();
    cmp_flag(s_ready, 1'b0);
    o_ready = 1'b1;
    feed(1, 12'h789);
    repeat (4) step();
    cmp_word(15'(got_q.size()), 15'h0003);
    cmp_word(got_q[0][29:15] ^ got_q[1][29:15] ^ got_q[2][29:15], 15'h02fc);
    cmp_word(got_q[0][29:15], 15'h0123);
    cmp_word(got_q[2][29:15], 15'h0789);
    $display("test stall done");
  endtask
  task automatic t_sync(input logic on, input int exp);
    int c0;
    link_init = on;
    link_en = 1'b0;
    // Running oscillators, so that alignment has something to clear
    fa = 32'h0123_4567;
    fb = 32'h0765_4321;
    step();
    link_en = 1'b1;
    c0 = pulse_cnt;
    partner_u.sync_run(6);
    repeat (4) step();
    cmp_word(15'(pulse_cnt - c0), 15'(exp));
    link_init = 1'b0;
    $display("test sync done");
  endtask
  task automatic t_sysref();
    int c0 = pulse_cnt;
    partner_u.sysref_pulse();
    repeat (3) step();
    cmp_word(15'(pulse_cnt - c0), 15'h0000);
    // Words settle before arming; later quadrant checks rely on the clear
    fa = 32'h0000_0000;
    fb = 32'h0000_0000;
    arm = 1'b1;
    repeat (2) step();
    partner_u.sysref_pulse();
    repeat (3) step();
    cmp_word(15'(pulse_cnt - c0), 15'h0001);
    partner_u.sysref_pulse();
    repeat (3) step();
    cmp_word(15'(pulse_cnt - c0), 15'h0001);
    arm = 1'b0;
    $display("test sysref done");
  endtask
  // Flat input settles every symmetric stage to the scaled input value
  task automatic t_decim(input ddcsd_pkg::ddcsd_dec_t d, input logic w, input logic sb,
      input logic [15:0] ph, input int k, input logic ec, input logic [14:0] ei,
      input logic [14:0] eq);
    int e = 256 >> k;
    dec = d;
    wide = w;
    mix_b = sb;
    pa = ph;
    pb = ~ph;
    step();
    got_q.delete();
    feed(256, 12'h040);
    repeat (8) step();
    cmp_flag(got_q.size() + 1 >= e && got_q.size() <= e + 1, 1'b1);
    cmp_flag(got_q[$][30], ec);
    cmp_word(got_q[$][29:15], ei);
    cmp_word(got_q[$][14:0], eq);
    $display("test decimation %0d done", k);
  endtask
  // Follows the settled wideband case: a step to zero exposes the final
  // block's centre weight, which a flat input cannot tell apart
  task automatic t_wide();
    got_q.delete();
    feed(4, 12'h000);
    repeat (3) step();
    cmp_word(15'(got_q.size()), 15'h0001);
    cmp_word(got_q[0][29:15], 15'h00a0);
    $display("test wideband step done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, s_valid, mix_b, link_init, arm, link_en, wide} = '0;
    {sample, fa, fb, pa, pb} = '0;
    o_ready = 1'b1;
    dec = ddcsd_pkg::DEC_NONE;
    repeat (16) @(posedge clk);
    #5 rst_n = 1'b1;
    t_bypass();
    t_stall();
    t_sync(1'b1, 1);
    t_sync(1'b0, 0);
    t_sysref();
    t_decim(ddcsd_pkg::DEC_2, 1'b0, 1'b0, 16'h0000, 1, 1'b0, 15'h0200, 15'h0000);
    t_decim(ddcsd_pkg::DEC_4, 1'b0, 1'b0, 16'h0000, 2, 1'b1, 15'h0200, 15'h0000);
    t_decim(ddcsd_pkg::DEC_4, 1'b1, 1'b0, 16'h0000, 2, 1'b1, 15'h0200, 15'h0000);
    t_wide();
    t_decim(ddcsd_pkg::DEC_8, 1'b0, 1'b0, 16'h0000, 3, 1'b1, 15'h0200, 15'h0000);
    t_decim(ddcsd_pkg::DEC_16, 1'b0, 1'b0, 16'h0000, 4, 1'b1, 15'h0200, 15'h0000);
    t_decim(ddcsd_pkg::DEC_4, 1'b0, 1'b0, 16'h4000, 2, 1'b1, 15'h0000, 15'h7e00);
    t_decim(ddcsd_pkg::DEC_4, 1'b0, 1'b1, 16'h4000, 2, 1'b1, 15'h7e00, 15'h0000);
    close_out();
  end
  // About 1940 cycles are expected; cut off well beyond that
  initial begin
    #(6000 * 50);
    failures++;
    close_out();
  end
endmodule // tb_ddc_nco_sync_decimation
